// [design/acsc_defines.svh]
/*
  Constants of the serial conversion controller: timing figures, the clock
  rate, serial word lengths and reset values.
  Assumes inclusion by bare name from any file of the block.
*/
`ifndef ACSC_DEFINES_SVH
`define ACSC_DEFINES_SVH

`define ACSC_CLK_MHZ         50
`define ACSC_CONVERT_STROBE_TIME_NS    3200
// Longest time, so the count rounds down
`define ACSC_CONVERT_STROBE_CYCLES     ((`ACSC_CONVERT_STROBE_TIME_NS * `ACSC_CLK_MHZ) / 1000)
`define ACSC_RESULT_BITS     16
`define ACSC_CFG_BITS        2
`define ACSC_FIFO_DEPTH      16
`define ACSC_CFG_RESET       2'h2
`define ACSC_ZERO_CODE       16'h0000

`endif

// [design/acsc_pkg.sv]
/*
  Types of the serial conversion controller.
  Assumes acsc_defines.svh is on the include path.
*/
`include "acsc_defines.svh"

package acsc_pkg;

  typedef enum logic [1:0] {
    ACSC_SAMPLE  = 2'b00,
    ACSC_CONVERT = 2'b01,
    ACSC_SLEEP   = 2'b10
  } acsc_state_t;

  typedef struct packed {
    logic single_ended;
    logic odd_sign;
  } acsc_mux_cfg_t;

  typedef struct packed {
    logic [`ACSC_RESULT_BITS-1:0] pos;
    logic [`ACSC_RESULT_BITS-1:0] neg;
  } acsc_sample_t;

endpackage

// [design/acsc_fifo.sv]
/*
  Synchronous FIFO with valid/ready on both sides, width and depth as
  parameters; depth must be a power of two.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/10ps

module acsc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;

  // Extra pointer bit tells full from empty
  assign in_ready  = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge mclk) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
    end else if (in_valid && in_ready) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_ptr <= '0;
    end else if (out_valid && out_ready) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

endmodule

// [design/acsc_top.sv]
/*
  Conversion sequencing and serial result/config port of a 16-bit converter.
  Assumes convert strobe, shift clock and config input come from pins
  asynchronous to mclk, and that analog inputs arrive as 16-bit codes
  scaled to the reference span.
*/
`timescale 1ns/10ps
`include "acsc_defines.svh"

module acsc_top #(
  parameter bit TWO_CHANNEL = 1'b1,
  parameter int CONVERT_STROBE_CYCLES = `ACSC_CONVERT_STROBE_CYCLES,
  parameter int FIFO_DEPTH  = `ACSC_FIFO_DEPTH
) (
  input  wire logic                         mclk,
  input  wire logic                         sys_rst,
  input  wire logic                         convert_strobe,
  input  wire logic                         shift_clk,
  input  wire logic                         serial_config_in,
  input  wire logic [`ACSC_RESULT_BITS-1:0] analog_input_a,
  input  wire logic [`ACSC_RESULT_BITS-1:0] analog_input_b,
  output logic                              serial_result_out,
  output logic                              serial_result_oe,
  output logic                              sleep_state,
  output logic                              convert_strobe_busy
);

  localparam int RB = `ACSC_RESULT_BITS;
  localparam int CW = $clog2(CONVERT_STROBE_CYCLES + 1);

  function automatic logic [RB-1:0] diff_code(input acsc_pkg::acsc_sample_t s);
    // Negative difference clips to zero; top code is reference minus one step
    diff_code = (s.pos > s.neg) ? RB'(s.pos - s.neg) : `ACSC_ZERO_CODE;
  endfunction

  // Two-flop synchronisers and edge finders
  logic [1:0] convert_strobe_sync;
  logic [1:0] sck_sync;
  logic [1:0] sdi_sync;
  logic       convert_strobe_d;
  logic       sck_d;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      convert_strobe_sync <= 2'h0;
      sck_sync  <= 2'h0;
      sdi_sync  <= 2'h0;
      convert_strobe_d    <= 1'b0;
      sck_d     <= 1'b0;
    end else begin
      convert_strobe_sync <= {convert_strobe_sync[0], convert_strobe};
      sck_sync  <= {sck_sync[0], shift_clk};
      sdi_sync  <= {sdi_sync[0], serial_config_in};
      convert_strobe_d    <= convert_strobe_sync[1];
      sck_d     <= sck_sync[1];
    end
  end

  logic convert_strobe_rise;
  logic convert_strobe_fall;
  logic sck_rise;
  logic sck_fall;
  assign convert_strobe_rise = convert_strobe_sync[1] && !convert_strobe_d;
  assign convert_strobe_fall = !convert_strobe_sync[1] && convert_strobe_d;
  assign sck_rise  = sck_sync[1] && !sck_d && !convert_strobe_sync[1];
  assign sck_fall  = !sck_sync[1] && sck_d && !convert_strobe_sync[1];

  // Configuration capture
  acsc_pkg::acsc_mux_cfg_t cfg_active;
  logic [`ACSC_CFG_BITS-1:0] cfg_shift;
  logic [1:0]                cfg_count;
  logic                      cfg_done;
  assign cfg_done = (cfg_count == 2'(`ACSC_CFG_BITS));

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_shift <= `ACSC_CFG_RESET;
      cfg_count <= 2'h0;
    end else if (convert_strobe_rise) begin
      cfg_count <= 2'h0;
    end else if (TWO_CHANNEL && sck_rise && !cfg_done) begin
      cfg_shift <= {cfg_shift[0], sdi_sync[1]};
      cfg_count <= cfg_count + 2'h1;
    end
    // Bits past the second are dropped
  end

  // Word only takes effect at the next conversion start
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_active <= acsc_pkg::acsc_mux_cfg_t'(`ACSC_CFG_RESET);
    end else if (convert_strobe_rise && cfg_done) begin
      cfg_active <= acsc_pkg::acsc_mux_cfg_t'(cfg_shift);
    end
  end

  // Input multiplexer, evaluated with the configuration in force at start
  acsc_pkg::acsc_mux_cfg_t cfg_use;
  acsc_pkg::acsc_sample_t  next_sample;
  assign cfg_use = cfg_done ? acsc_pkg::acsc_mux_cfg_t'(cfg_shift) : cfg_active;

  always_comb begin
    next_sample.pos = analog_input_a;
    next_sample.neg = analog_input_b;
    if (TWO_CHANNEL) begin
      if (cfg_use.single_ended) begin
        next_sample.pos = cfg_use.odd_sign ? analog_input_b : analog_input_a;
        next_sample.neg = `ACSC_ZERO_CODE;
      end else if (cfg_use.odd_sign) begin
        next_sample.pos = analog_input_b;
        next_sample.neg = analog_input_a;
      end
    end
  end

  // Conversion sequencer
  acsc_pkg::acsc_state_t  state;
  acsc_pkg::acsc_sample_t held;
  logic [CW-1:0]          convert_strobe_count;
  logic                   push_valid;
  logic                   push_ready;
  logic                   convert_strobe_done;
  assign convert_strobe_done  = (convert_strobe_count == CW'(CONVERT_STROBE_CYCLES));
  assign push_valid = (state == acsc_pkg::ACSC_CONVERT) && convert_strobe_done;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      held <= '0;
    end else if (convert_strobe_rise) begin
      held <= next_sample;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state      <= acsc_pkg::ACSC_SAMPLE;
      convert_strobe_count <= '0;
    end else begin
      case (state)
        acsc_pkg::ACSC_SAMPLE: begin
          if (convert_strobe_rise) begin
            state      <= acsc_pkg::ACSC_CONVERT;
            convert_strobe_count <= '0;
          end
        end
        acsc_pkg::ACSC_CONVERT: begin
          if (!convert_strobe_done) begin
            convert_strobe_count <= convert_strobe_count + 1'b1;
          end else if (push_ready) begin
            // Held while the buffer is full; that stall is the back-pressure
            state <= convert_strobe_sync[1] ? acsc_pkg::ACSC_SLEEP : acsc_pkg::ACSC_SAMPLE;
          end
          if (convert_strobe_fall) begin
            // Early fall abandons the conversion
            state <= acsc_pkg::ACSC_SAMPLE;
          end
        end
        acsc_pkg::ACSC_SLEEP: begin
          if (convert_strobe_fall) begin
            state <= acsc_pkg::ACSC_SAMPLE;
          end
        end
        default: begin
          state <= acsc_pkg::ACSC_SAMPLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_state <= 1'b0;
      convert_strobe_busy   <= 1'b0;
    end else begin
      sleep_state <= (state == acsc_pkg::ACSC_SLEEP);
      convert_strobe_busy   <= (state == acsc_pkg::ACSC_CONVERT);
    end
  end

  // Result buffer
  logic          pop_valid;
  logic [RB-1:0] pop_data;
  logic          pop_take;
  assign pop_take = convert_strobe_fall && pop_valid;

  acsc_fifo #(
    .WIDTH (RB),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (diff_code(held)),
    .out_valid (pop_valid),
    .out_ready (pop_take),
    .out_data  (pop_data)
  );

  // Result shifter
  logic [RB-1:0] out_shift;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      out_shift         <= `ACSC_ZERO_CODE;
      serial_result_out <= 1'b0;
      serial_result_oe  <= 1'b0;
    end else if (convert_strobe_rise) begin
      serial_result_oe  <= 1'b0;
      serial_result_out <= 1'b0;
    end else if (convert_strobe_fall) begin
      // Empty buffer means no finished result: send zeros
      out_shift         <= pop_valid ? pop_data : `ACSC_ZERO_CODE;
      serial_result_out <= pop_valid ? pop_data[RB-1] : 1'b0;
      serial_result_oe  <= 1'b1;
    end else if (sck_fall) begin
      out_shift         <= {out_shift[RB-2:0], 1'b0};
      serial_result_out <= out_shift[RB-2];
    end
  end

endmodule

// [bench/acsc_top_asserts.sv]
/*
  Pin-level checker of the conversion controller, bound into acsc_top.
  Assumes pin edges at least 2 mclk apart, a 2-flop pin synchroniser and an
  edge flop behind it, so pin events act 3 to 4 mclk late.
*/
`timescale 1ns/10ps
`include "acsc_defines.svh"

module acsc_top_asserts #(
  parameter int CONVERT_STROBE_CYCLES = `ACSC_CONVERT_STROBE_CYCLES
) (
  input wire logic                         mclk,
  input wire logic                         sys_rst,
  input wire logic                         convert_strobe,
  input wire logic                         shift_clk,
  input wire logic                         serial_config_in,
  input wire logic [`ACSC_RESULT_BITS-1:0] analog_input_a,
  input wire logic [`ACSC_RESULT_BITS-1:0] analog_input_b,
  input wire logic                         serial_result_out,
  input wire logic                         serial_result_oe,
  input wire logic                         sleep_state,
  input wire logic                         convert_strobe_busy
);
  logic [15:0] run;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // Length of the current busy stretch
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      run <= 16'h0000;
    end else if (convert_strobe_busy) begin
      run <= run + 16'h0001;
    end else begin
      run <= 16'h0000;
    end
  end

  AST_START: assert property ($rose(convert_strobe) |-> ##[3:5] convert_strobe_busy)
    else $error("conversion did not start after strobe rise");
  AST_FLOAT: assert property ($rose(convert_strobe) |-> ##[3:4] !serial_result_oe)
    else $error("result driver still on after strobe rise");
  AST_ENABLE: assert property ($fell(convert_strobe) |-> ##[3:4] serial_result_oe)
    else $error("result driver not on after strobe fall");
  AST_HIGH_OFF: assert property (convert_strobe [*6] |-> !serial_result_oe)
    else $error("result driver on while strobe high");
  AST_OFF_ZERO: assert property (!serial_result_oe |-> !serial_result_out)
    else $error("result line not low while disabled");
  AST_CONVERT_STROBE_LEN: assert property ($fell(convert_strobe_busy) && convert_strobe |->
      run >= CONVERT_STROBE_CYCLES && run <= CONVERT_STROBE_CYCLES + 1)
    else $error("conversion length wrong");
  AST_SLEEP: assert property ($fell(convert_strobe_busy) && convert_strobe |-> ##[1:3] sleep_state)
    else $error("no sleep after finished conversion");
  // Sleep may outlast the strobe fall by the synchroniser delay
  AST_SLEEP_EXCL: assert property (sleep_state |->
      !convert_strobe_busy && (convert_strobe || $past(convert_strobe, 4)))
    else $error("sleep while busy or long after strobe fall");
  AST_WAKE: assert property (!convert_strobe [*8] |-> !sleep_state)
    else $error("still asleep with strobe low");
  AST_BIT_HOLD: assert property ((shift_clk && !convert_strobe) [*3] |->
      $stable(serial_result_out))
    else $error("result bit changed while shift clock high");
endmodule

bind acsc_top acsc_top_asserts #(.CONVERT_STROBE_CYCLES(CONVERT_STROBE_CYCLES)) acsc_top_asserts_inst (
  .mclk(mclk), .sys_rst(sys_rst), .convert_strobe(convert_strobe), .shift_clk(shift_clk),
  .serial_config_in(serial_config_in), .analog_input_a(analog_input_a),
  .analog_input_b(analog_input_b), .serial_result_out(serial_result_out),
  .serial_result_oe(serial_result_oe), .sleep_state(sleep_state), .convert_strobe_busy(convert_strobe_busy));

// [bench/acsc_host_model.sv]
/*
  Host serial controller: strobe, shift clock and config input.
  Assumes mclk at 50 MHz; shift clock of 8 mclk, low 5 and high 3.
*/
`timescale 1ns/10ps

module acsc_host_model (
  input  wire logic mclk,
  input  wire logic serial_result_out,
  output logic      convert_strobe,
  output logic      shift_clk,
  output logic      serial_config_in
);
  logic [31:0] rx;

  initial begin
    convert_strobe = 1'b0;
    shift_clk = 1'b0;
    serial_config_in = 1'b0;
    rx = 32'h00000000;
  end

  task automatic transfer(input int hi, input logic [1:0] cfg, input int nclk);
    int i;
    rx = 32'h00000000;
    @(posedge mclk);
    convert_strobe <= 1'b1;
    repeat (hi) @(posedge mclk);
    convert_strobe <= 1'b0;
    serial_config_in <= cfg[1];
    repeat (6) @(posedge mclk);
    for (i = 0; i < nclk; i++) begin
      shift_clk <= 1'b1;
      rx = {rx[30:0], serial_result_out};
      repeat (3) @(posedge mclk);
      shift_clk <= 1'b0;
      // Junk after the word, so a late capture shows
      serial_config_in <= (i == 0) ? cfg[0] : ~serial_config_in;
      repeat (5) @(posedge mclk);
    end
  endtask
endmodule

// [bench/acsc_top_tb_top.sv]
/*
  Self-checking bench of acsc_top with the host model on the serial side.
  Assumes conversion shortened to 8 mclk; transfer k reads conversion k.
*/
`timescale 1ns/10ps
`include "acsc_defines.svh"

module acsc_top_tb_top;
  logic        mclk;
  logic        sys_rst;
  logic        convert_strobe;
  logic        shift_clk;
  logic        serial_config_in;
  logic [15:0] analog_input_a;
  logic [15:0] analog_input_b;
  logic        serial_result_out;
  logic        serial_result_oe;
  logic        sleep_state;
  logic        convert_strobe_busy;
  int          err_count;
  int          checks;
  logic        single_out;
  logic [15:0] single_rx;

  acsc_top #(.TWO_CHANNEL(1'b1), .CONVERT_STROBE_CYCLES(8), .FIFO_DEPTH(16)) acsc_top_inst (
    .mclk(mclk), .sys_rst(sys_rst), .convert_strobe(convert_strobe),
    .shift_clk(shift_clk), .serial_config_in(serial_config_in),
    .analog_input_a(analog_input_a), .analog_input_b(analog_input_b),
    .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
    .sleep_state(sleep_state), .convert_strobe_busy(convert_strobe_busy));

  // One-channel variant on the same pins; it must ignore the config input
  acsc_top #(.TWO_CHANNEL(1'b0), .CONVERT_STROBE_CYCLES(8), .FIFO_DEPTH(16)) acsc_top_single_inst (
    .mclk(mclk), .sys_rst(sys_rst), .convert_strobe(convert_strobe),
    .shift_clk(shift_clk), .serial_config_in(serial_config_in),
    .analog_input_a(analog_input_a), .analog_input_b(analog_input_b),
    .serial_result_out(single_out), .serial_result_oe(),
    .sleep_state(), .convert_strobe_busy());

  // Host capture for the one-channel part, on the rising shift clock
  always @(posedge shift_clk) begin
    single_rx <= {single_rx[14:0], single_out};
  end

  acsc_host_model host_inst (
    .mclk(mclk), .serial_result_out(serial_result_out), .convert_strobe(convert_strobe),
    .shift_clk(shift_clk), .serial_config_in(serial_config_in));

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Config sent in one transfer shapes the word of the next
  task automatic sc_mux;
    logic [1:0]  cfg [4] = '{2'b11, 2'b00, 2'b01, 2'b10};
    logic [15:0] exp [4] = '{16'h9000, 16'h3000, 16'h6000, 16'h0000};
    for (int i = 0; i < 4; i++) begin
      host_inst.transfer(20, cfg[i], 16);
      cmp_word(host_inst.rx[15:0], exp[i]);
      cmp_word(single_rx, 16'h6000);
    end
  endtask

  task automatic sc_tail;
    analog_input_a <= 16'hFFFF;
    analog_input_b <= 16'h0000;
    host_inst.transfer(20, 2'b10, 20);
    cmp_word(host_inst.rx[19:4], 16'hFFFF);
    cmp_word({12'h000, host_inst.rx[3:0]}, 16'h0000);
  endtask

  // Early fall drops the conversion, so nothing is buffered
  task automatic sc_abort;
    analog_input_a <= 16'h1234;
    host_inst.transfer(2, 2'b10, 16);
    cmp_word(host_inst.rx[15:0], 16'h0000);
  endtask

  task automatic sc_sleep;
    fork
      host_inst.transfer(40, 2'b10, 16);
      begin
        repeat (7) @(posedge mclk);
        cmp_bit(convert_strobe_busy, 1'b1);
        repeat (23) @(posedge mclk);
        cmp_bit(sleep_state, 1'b1);
        cmp_bit(serial_result_oe, 1'b0);
      end
    join
    cmp_word(host_inst.rx[15:0], 16'h1234);
    cmp_bit(sleep_state, 1'b0);
    cmp_bit(serial_result_oe, 1'b1);
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    end_sim();
  end

  initial begin
    err_count = 0;
    checks = 0;
    sys_rst = 1'b1;
    analog_input_a = 16'h9000;
    analog_input_b = 16'h3000;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (5) @(posedge mclk);
    sc_mux();
    sc_tail();
    sc_abort();
    sc_sleep();
    end_sim();
  end
endmodule
